/* common/pcseq_defs.vh */
// Constants shared by the program counter sequencer files.
`ifndef PCSEQ_DEFS_VH
`define PCSEQ_DEFS_VH

// ==========================================================================
// Widths and reset values
// ==========================================================================
`define PCSEQ_PC_W 24
`define PCSEQ_WREG_W 16
`define PCSEQ_ABS_W 23
`define PCSEQ_RESET_PC 24'h000000
`define PCSEQ_SP_RESET 16'h0800

// ==========================================================================
// Counter steps
// ==========================================================================
`define PCSEQ_STEP_SEQ 24'h000002
`define PCSEQ_STEP_CALL_ABS 24'h000004

// ==========================================================================
// Flow-change operation codes
// ==========================================================================
`define PCSEQ_OP_W 4
`define PCSEQ_OP_SEQ 4'h0
`define PCSEQ_OP_BRANCH 4'h1
`define PCSEQ_OP_BRANCH_COND 4'h2
`define PCSEQ_OP_CALL_ABS 4'h3
`define PCSEQ_OP_CALL_IND 4'h4
`define PCSEQ_OP_CALL_LONG 4'h5
`define PCSEQ_OP_JUMP_ABS 4'h6
`define PCSEQ_OP_JUMP_IND 4'h7
`define PCSEQ_OP_JUMP_LONG 4'h8
`define PCSEQ_OP_CALL_REL 4'h9
`define PCSEQ_OP_CALL_COMP 4'ha
`define PCSEQ_OP_RETURN 4'hb
`define PCSEQ_OP_RETURN_LIT 4'hc
`define PCSEQ_OP_RETURN_EXC 4'hd

// ==========================================================================
// Stack state machine
// ==========================================================================
`define PCSEQ_ST_IDLE 2'h0
`define PCSEQ_ST_POP_LO 2'h1
`define PCSEQ_ST_POP_HI 2'h2

`endif

/* design/pcseq_target.v */
// Target address adder for relative and computed flow changes.
`timescale 1ns/10ps
`default_nettype none
`include "pcseq_defs.vh"

module pcseq_target (
    input wire [`PCSEQ_PC_W-1:0] pc,
    input wire [`PCSEQ_WREG_W-1:0] offset,
    output wire [`PCSEQ_PC_W-1:0] target
);
    // ======================================================================
    // Signed offset scaled by two
    // ======================================================================
    // Sign extend to counter width, then double; word steps stay even.
    wire [`PCSEQ_PC_W-1:0] ext;
    assign ext = {{(`PCSEQ_PC_W-`PCSEQ_WREG_W){offset[`PCSEQ_WREG_W-1]}},
                  offset};
    assign target = pc + {ext[`PCSEQ_PC_W-2:0], 1'b0}; // see RULE_04
endmodule // pcseq_target

`default_nettype wire

/* design/pcseq_retbuf.v */
// Return address capture register for a two-word stack push.
`timescale 1ns/10ps
`default_nettype none
`include "pcseq_defs.vh"

module pcseq_retbuf (
    input wire ref_clk,
    input wire rst,
    input wire load,
    input wire [`PCSEQ_PC_W-1:0] addr_in,
    output reg [`PCSEQ_PC_W-1:0] addr_q
);
    // ======================================================================
    // Hold register
    // ======================================================================
    // Keeps the return address for the second push word.
    always @(posedge ref_clk) begin
        if (rst) begin
            addr_q <= `PCSEQ_RESET_PC;
        end else if (load) begin
            addr_q <= addr_in;
        end
    end
endmodule // pcseq_retbuf

`default_nettype wire

/* design/pcseq_core.v */
// Next program counter sequencer with return-address stack control.
//
// Operation
// RULE_01: Hold 24-bit counter addressing program memory.
// RULE_02: Instruction words sit two addresses apart.
// RULE_03: Sequential execution adds two to counter.
// RULE_04: Relative branch adds twice signed offset.
// RULE_05: Conditional branch: false adds two, true branches.
// RULE_06: Offsets signed 16-bit; absolute targets 23-bit.
// RULE_07: Absolute call loads literal, pushes counter plus four.
// RULE_08: Indirect, long, relative calls push counter plus two.
// RULE_09: Indirect call or jump loads named register.
// RULE_10: Long forms concatenate next register above named.
// RULE_11: Computed relative call adds twice register, pushes.
// RULE_12: Exception loads vector, pushes counter plus two.
// RULE_13: Returns pop top-of-stack entry into counter.
// RULE_14: Exception return pops top-of-stack entry.
// RULE_15: Active repeat holds counter unchanged.
// RULE_16: Loop end executed reloads loop start address.
// RULE_17: Pushes go through stack pointer register.
// RULE_18: Plain jumps leave stack untouched.
`timescale 1ns/10ps
`default_nettype none
`include "pcseq_defs.vh"

module pcseq_core #(
    parameter PC_W = `PCSEQ_PC_W,
    parameter WREG_W = `PCSEQ_WREG_W
) (
    input wire ref_clk,
    input wire rst,
    input wire instr_valid,
    input wire [`PCSEQ_OP_W-1:0] flow_op,
    input wire cond_true,
    input wire [WREG_W-1:0] signed_branch_offset,
    input wire [`PCSEQ_ABS_W-1:0] absolute_target_literal,
    input wire [WREG_W-1:0] named_working_register,
    input wire [WREG_W-1:0] next_working_register,
    input wire exception_req,
    input wire [PC_W-1:0] exception_vector_table,
    input wire repeat_active,
    input wire loop_active,
    input wire [PC_W-1:0] loop_start_address,
    input wire [PC_W-1:0] loop_end_address,
    input wire [WREG_W-1:0] stack_rd_data,
    output reg [PC_W-1:0] fetch_addr_q,
    output wire busy,
    output reg stack_wr_q,
    output reg stack_rd_q,
    output reg [WREG_W-1:0] stack_addr_q,
    output reg [WREG_W-1:0] stack_wr_data_q,
    output reg [WREG_W-1:0] stack_pointer_register_q
);
    // ======================================================================
    // Decode helpers
    // ======================================================================
    // Ops that push a return address of counter plus two.
    function is_push2;
        input [`PCSEQ_OP_W-1:0] op;
        begin
            is_push2 = (op == `PCSEQ_OP_CALL_IND) ||
                       (op == `PCSEQ_OP_CALL_LONG) ||
                       (op == `PCSEQ_OP_CALL_REL) ||
                       (op == `PCSEQ_OP_CALL_COMP); // see RULE_08
        end
    endfunction

    // Ops that pop the top-of-stack entry.
    function is_pop;
        input [`PCSEQ_OP_W-1:0] op;
        begin
            is_pop = (op == `PCSEQ_OP_RETURN) ||
                     (op == `PCSEQ_OP_RETURN_LIT) ||
                     (op == `PCSEQ_OP_RETURN_EXC); // see RULE_13
        end
    endfunction

    // ======================================================================
    // State
    // ======================================================================
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg push_hi_q;
    reg [PC_W-1:0] pc_d;
    reg [PC_W-1:0] ret_d;
    reg push_d;
    reg [WREG_W-1:0] pop_lo_q;
    wire [PC_W-1:0] rel_target;
    wire [PC_W-1:0] ret_q;
    wire [WREG_W-1:0] rel_off;
    wire [PC_W-1:0] long_reg;
    wire [PC_W-1:0] short_reg;
    wire [PC_W-1:0] seq_pc;

    // Pops and the second push word stall the fetch stream.
    assign busy = (state_q != `PCSEQ_ST_IDLE) || push_hi_q;

    assign seq_pc = fetch_addr_q + `PCSEQ_STEP_SEQ; // see RULE_03
    assign short_reg = {{(PC_W-WREG_W){1'b0}}, named_working_register};
    // High word above the named register supplies the upper bits.
    assign long_reg = {next_working_register[PC_W-WREG_W-1:0],
                       named_working_register}; // see RULE_10
    // Computed relative call scales the register, others the literal.
    assign rel_off = (flow_op == `PCSEQ_OP_CALL_COMP) ?
                     named_working_register : signed_branch_offset;

    pcseq_target u_target (
        .pc(fetch_addr_q),
        .offset(rel_off),
        .target(rel_target)
    );

    pcseq_retbuf u_retbuf (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(push_d),
        .addr_in(ret_d),
        .addr_q(ret_q)
    );

    // ======================================================================
    // Next counter selection
    // ======================================================================
    // Exception outranks the instruction; repeat outranks looping so a
    // repeated instruction at the loop end is not cut short.
    always @* begin
        pc_d = fetch_addr_q;
        ret_d = seq_pc;
        push_d = 1'b0;
        state_d = state_q;
        case (state_q)
            `PCSEQ_ST_IDLE: begin
                if (push_hi_q) begin
                    pc_d = fetch_addr_q;
                end else if (exception_req) begin
                    pc_d = exception_vector_table; // see RULE_12
                    ret_d = seq_pc;
                    push_d = 1'b1;
                end else if (instr_valid) begin
                    if (repeat_active) begin
                        pc_d = fetch_addr_q; // see RULE_15
                    end else begin
                        case (flow_op)
                            `PCSEQ_OP_SEQ: begin
                                pc_d = seq_pc;
                            end
                            `PCSEQ_OP_BRANCH: begin
                                pc_d = rel_target; // see RULE_04
                            end
                            `PCSEQ_OP_BRANCH_COND: begin
                                // False condition falls through by one word.
                                pc_d = cond_true ? rel_target :
                                       seq_pc; // see RULE_05
                            end
                            `PCSEQ_OP_CALL_ABS: begin
                                // 23-bit literal, upper bit zero.
                                pc_d = {1'b0, absolute_target_literal};
                                ret_d = fetch_addr_q +
                                        `PCSEQ_STEP_CALL_ABS; // see RULE_07
                                push_d = 1'b1;
                            end
                            `PCSEQ_OP_CALL_IND: begin
                                pc_d = short_reg; // see RULE_09
                                push_d = 1'b1;
                            end
                            `PCSEQ_OP_CALL_LONG: begin
                                pc_d = long_reg; // see RULE_10
                                push_d = 1'b1;
                            end
                            `PCSEQ_OP_JUMP_ABS: begin
                                pc_d = {1'b0,
                                        absolute_target_literal}; // see RULE_06
                            end
                            `PCSEQ_OP_JUMP_IND: begin
                                pc_d = short_reg; // see RULE_18
                            end
                            `PCSEQ_OP_JUMP_LONG: begin
                                pc_d = long_reg; // see RULE_18
                            end
                            `PCSEQ_OP_CALL_REL,
                            `PCSEQ_OP_CALL_COMP: begin
                                pc_d = rel_target; // see RULE_11
                                push_d = 1'b1;
                            end
                            `PCSEQ_OP_RETURN,
                            `PCSEQ_OP_RETURN_LIT,
                            `PCSEQ_OP_RETURN_EXC: begin
                                state_d = `PCSEQ_ST_POP_HI; // see RULE_14
                            end
                            default: begin
                                pc_d = seq_pc;
                            end
                        endcase
                        // Loop end wraps back only on plain fall-through.
                        if (loop_active && !is_pop(flow_op) &&
                            (fetch_addr_q == loop_end_address) &&
                            (pc_d == seq_pc) && !push_d) begin
                            pc_d = loop_start_address; // see RULE_16
                        end
                    end
                end
            end
            `PCSEQ_ST_POP_HI: begin
                state_d = `PCSEQ_ST_POP_LO;
            end
            `PCSEQ_ST_POP_LO: begin
                // Low word read earlier, high word arrives now.
                pc_d = {stack_rd_data[PC_W-WREG_W-1:0],
                        pop_lo_q}; // see RULE_13
                state_d = `PCSEQ_ST_IDLE;
            end
            default: begin
                state_d = `PCSEQ_ST_IDLE;
            end
        endcase
    end

    // ======================================================================
    // Counter and stack registers
    // ======================================================================
    // Stack grows upward: low word first, then high word, each at sp,
    // sp advancing by two per word. Pop reads sp-4 then sp-2.
    always @(posedge ref_clk) begin
        if (rst) begin
            fetch_addr_q <= `PCSEQ_RESET_PC; // see RULE_01
            state_q <= `PCSEQ_ST_IDLE;
            push_hi_q <= 1'b0;
            stack_wr_q <= 1'b0;
            stack_rd_q <= 1'b0;
            stack_addr_q <= 16'h0000;
            stack_wr_data_q <= 16'h0000;
            stack_pointer_register_q <= `PCSEQ_SP_RESET;
            pop_lo_q <= 16'h0000;
        end else begin
            // Bit 0 forced low keeps every fetch on a word step.
            fetch_addr_q <= {pc_d[PC_W-1:1], 1'b0}; // see RULE_02
            state_q <= state_d;
            stack_wr_q <= 1'b0;
            stack_rd_q <= 1'b0;
            push_hi_q <= 1'b0;
            if (push_d) begin
                stack_wr_q <= 1'b1; // see RULE_17
                stack_addr_q <= stack_pointer_register_q;
                stack_wr_data_q <= ret_d[WREG_W-1:0];
                stack_pointer_register_q <= stack_pointer_register_q +
                                            16'h0002;
                push_hi_q <= 1'b1;
            end else if (push_hi_q) begin
                stack_wr_q <= 1'b1; // see RULE_17
                stack_addr_q <= stack_pointer_register_q;
                stack_wr_data_q <= {{(2*WREG_W-PC_W){1'b0}},
                                    ret_q[PC_W-1:WREG_W]};
                stack_pointer_register_q <= stack_pointer_register_q +
                                            16'h0002;
            end else if (state_q == `PCSEQ_ST_IDLE &&
                         state_d == `PCSEQ_ST_POP_HI) begin
                stack_rd_q <= 1'b1;
                stack_addr_q <= stack_pointer_register_q - 16'h0004;
                stack_pointer_register_q <= stack_pointer_register_q -
                                            16'h0004;
            end else if (state_q == `PCSEQ_ST_POP_HI) begin
                // First read answered with the low word.
                pop_lo_q <= stack_rd_data;
                stack_rd_q <= 1'b1;
                stack_addr_q <= stack_pointer_register_q + 16'h0002;
            end
        end
    end
endmodule // pcseq_core

`default_nettype wire

/* bench/pcseq_core_assertions.sv */
// Concurrent checks on the ports of the program counter sequencer core.
`timescale 1ns/10ps
`default_nettype none
`include "pcseq_defs.vh"

// ======================================================================
// Port checker
// ======================================================================
module pcseq_core_chk #(
    parameter PC_W = 24,
    parameter WREG_W = 16
) (
    input wire ref_clk,
    input wire rst,
    input wire instr_valid,
    input wire [3:0] flow_op,
    input wire exception_req,
    input wire [22:0] absolute_target_literal,
    input wire [PC_W-1:0] exception_vector_table,
    input wire repeat_active,
    input wire loop_active,
    input wire [PC_W-1:0] loop_start_address,
    input wire [PC_W-1:0] loop_end_address,
    input wire [PC_W-1:0] fetch_addr_q,
    input wire busy,
    input wire stack_wr_q,
    input wire stack_rd_q,
    input wire [WREG_W-1:0] stack_addr_q,
    input wire [WREG_W-1:0] stack_wr_data_q,
    input wire [WREG_W-1:0] stack_pointer_register_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A request counts only at an edge where the core is free to take it.
    wire take = !busy && instr_valid && !exception_req;
    wire seq = take && flow_op == `PCSEQ_OP_SEQ && !repeat_active;
    wire at_end = loop_active && fetch_addr_q == loop_end_address;
    wire [WREG_W-1:0] pc_lo = fetch_addr_q[WREG_W-1:0];
    wire [PC_W-1:0] lit_pc = {1'b0, absolute_target_literal[22:1], 1'b0};
    wire [PC_W-1:0] vec_pc = {exception_vector_table[PC_W-1:1], 1'b0};

    reset_state_a: assert property (disable iff (1'b0)
        rst |=> fetch_addr_q == `PCSEQ_RESET_PC &&
        stack_pointer_register_q == `PCSEQ_SP_RESET && !stack_wr_q)
        else $error("state wrong after reset");
    even_addr_a: assert property (fetch_addr_q[0] == 1'b0)
        else $error("odd fetch address");
    seq_step_a: assert property (seq && !at_end |=>
        fetch_addr_q == $past(fetch_addr_q) + `PCSEQ_STEP_SEQ)
        else $error("sequential step wrong");
    repeat_hold_a: assert property (take && repeat_active &&
        flow_op == `PCSEQ_OP_SEQ |=> $stable(fetch_addr_q))
        else $error("counter moved during repeat");
    loop_back_a: assert property (seq && at_end |=>
        fetch_addr_q == $past(loop_start_address))
        else $error("loop end did not return to start");
    jump_abs_a: assert property (take &&
        flow_op == `PCSEQ_OP_JUMP_ABS |=> fetch_addr_q == $past(lit_pc)
        && !stack_wr_q && $stable(stack_pointer_register_q))
        else $error("absolute jump wrong");
    call_push_a: assert property (take &&
        flow_op == `PCSEQ_OP_CALL_ABS |=> stack_wr_q &&
        stack_wr_data_q == $past(pc_lo) + 16'h0004 ##1 stack_wr_q &&
        stack_pointer_register_q == $past(stack_pointer_register_q, 2)
        + 16'h0004) else $error("call push wrong");
    ret_pop_a: assert property (take &&
        flow_op >= `PCSEQ_OP_RETURN |=> stack_rd_q && stack_addr_q ==
        $past(stack_pointer_register_q) - 16'h0004 ##1 stack_rd_q ##1 !busy)
        else $error("return pop wrong");
    exc_entry_a: assert property (!busy && exception_req |=>
        fetch_addr_q == $past(vec_pc) && stack_wr_q &&
        stack_wr_data_q == $past(pc_lo) + 16'h0002)
        else $error("exception entry wrong");

    cover property (take && flow_op == `PCSEQ_OP_CALL_ABS);
    cover property (take && flow_op == `PCSEQ_OP_RETURN_EXC);
    cover property (seq && at_end);
endmodule // pcseq_core_chk

bind pcseq_core pcseq_core_chk #(.PC_W(PC_W), .WREG_W(WREG_W)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .flow_op(flow_op), .exception_req(exception_req),
    .absolute_target_literal(absolute_target_literal),
    .exception_vector_table(exception_vector_table),
    .repeat_active(repeat_active), .loop_active(loop_active),
    .loop_start_address(loop_start_address),
    .loop_end_address(loop_end_address), .fetch_addr_q(fetch_addr_q),
    .busy(busy), .stack_wr_q(stack_wr_q), .stack_rd_q(stack_rd_q),
    .stack_addr_q(stack_addr_q), .stack_wr_data_q(stack_wr_data_q),
    .stack_pointer_register_q(stack_pointer_register_q)
);
`default_nettype wire

/* bench/pcseq_stack_model.sv */
// Data stack memory model facing the sequencer's stack port.
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// Stack memory
// ======================================================================
module pcseq_stack_model (
    input wire ref_clk,
    input wire stack_wr_q,
    input wire stack_rd_q,
    input wire [15:0] stack_addr_q,
    input wire [15:0] stack_wr_data_q,
    output wire [15:0] stack_rd_data
);
    reg [15:0] mem [0:255];
    reg [15:0] last_q = 16'h0000;
    // Read data answers in the strobe cycle; an idle bus flips every cycle
    // so that a late sample can never match a stale word by luck.
    assign stack_rd_data = stack_rd_q ? mem[stack_addr_q[8:1]] : ~last_q;
    // Word writes land on the strobe edge.
    always @(posedge ref_clk) begin
        if (stack_wr_q)
            mem[stack_addr_q[8:1]] <= stack_wr_data_q;
        last_q <= stack_rd_data;
    end
endmodule // pcseq_stack_model
`default_nettype wire

/* bench/pcseq_tb.sv */
// Self-checking testbench for the program counter sequencer core.
`timescale 1ns/10ps
`default_nettype none
`include "pcseq_defs.vh"

// ======================================================================
// Testbench
// ======================================================================
module tb;
    reg ref_clk = 1'b0, rst = 1'b1, iv = 1'b0, cond = 1'b0, exc = 1'b0;
    reg rep = 1'b0, lp = 1'b0;
    reg [3:0] op_r = 4'h0, op;
    reg [15:0] off = 16'h0000, wn = 16'h0000, wn1 = 16'h0000, exp_sp;
    reg [22:0] lit = 23'h000000;
    reg [23:0] vec = 24'h000000, ls = 24'h000000, le = 24'h000000, exp_pc;
    reg [23:0] rets [$];
    reg [31:0] r;
    wire [15:0] rd_data, saddr, wdata, sp;
    wire [23:0] pc;
    wire busy, swr, srd;
    integer num_errors = 0, n_tests = 0, seed = 81221, i;

    pcseq_core DUT (
        .ref_clk(ref_clk), .rst(rst), .instr_valid(iv), .flow_op(op_r),
        .cond_true(cond), .signed_branch_offset(off),
        .absolute_target_literal(lit), .named_working_register(wn),
        .next_working_register(wn1), .exception_req(exc),
        .exception_vector_table(vec), .repeat_active(rep),
        .loop_active(lp), .loop_start_address(ls), .loop_end_address(le),
        .stack_rd_data(rd_data), .fetch_addr_q(pc), .busy(busy),
        .stack_wr_q(swr), .stack_rd_q(srd), .stack_addr_q(saddr),
        .stack_wr_data_q(wdata), .stack_pointer_register_q(sp));
    pcseq_stack_model u_stack (.ref_clk(ref_clk), .stack_wr_q(swr),
        .stack_rd_q(srd), .stack_addr_q(saddr), .stack_wr_data_q(wdata),
        .stack_rd_data(rd_data));

    // Free-running core clock at 125 MHz.
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // Twice a signed word offset added to the counter.
    function [23:0] rel(input [23:0] p, input [15:0] o);
        rel = p + {{7{o[15]}}, o, 1'b0};
    endfunction

    task check(input [23:0] got, input [23:0] want);
        n_tests = n_tests + 1;
        if (got !== want) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                want);
        end
    endtask

    // One request, then a bounded wait for the core to go idle; the
    // expectation is built from the inputs the core actually took.
    task run(input [3:0] code, input take_exc, input [15:0] o);
        integer n;
        reg [23:0] ret;
        begin
            r = $random(seed);
            @(posedge ref_clk);
            op_r <= code;
            exc <= take_exc;
            iv <= !take_exc;
            off <= o;
            wn <= (code == `PCSEQ_OP_CALL_COMP) ? {1'b0, o[14:0]} : o;
            {wn1, lit} <= {r[31:16], r[22:0]};
            vec <= {r[23:1], 1'b0};
            cond <= r[0];
            @(posedge ref_clk);
            iv <= 1'b0;
            exc <= 1'b0;
            ret = exp_pc + ((op_r == `PCSEQ_OP_CALL_ABS) ? 24'h4 : 24'h2);
            if (exc)
                exp_pc = vec;
            else case (op_r)
                `PCSEQ_OP_SEQ: if (!rep) exp_pc = (lp && exp_pc == le) ? ls
                    : exp_pc + 24'h000002;
                `PCSEQ_OP_BRANCH, `PCSEQ_OP_CALL_REL: exp_pc = rel(exp_pc, off);
                `PCSEQ_OP_BRANCH_COND: exp_pc = cond ? rel(exp_pc, off)
                    : exp_pc + 24'h000002;
                `PCSEQ_OP_CALL_ABS, `PCSEQ_OP_JUMP_ABS: exp_pc = {1'b0, lit};
                `PCSEQ_OP_CALL_IND, `PCSEQ_OP_JUMP_IND: exp_pc = {8'h00, wn};
                `PCSEQ_OP_CALL_LONG, `PCSEQ_OP_JUMP_LONG: exp_pc = {wn1[7:0], wn};
                `PCSEQ_OP_CALL_COMP: exp_pc = rel(exp_pc, wn);
                default: begin
                    exp_pc = rets.pop_back();
                    exp_sp = exp_sp - 16'h0004;
                end
            endcase
            exp_pc[0] = 1'b0;
            if (exc || op_r inside {4'h3, 4'h4, 4'h5, 4'h9, 4'ha}) begin
                rets.push_back(ret);
                exp_sp = exp_sp + 16'h0004;
            end
            n = 0;
            #1;
            while (busy !== 1'b0 && n < 8) begin
                @(posedge ref_clk);
                #1;
                n = n + 1;
            end
            check(pc, exp_pc);
            check({8'h00, sp}, {8'h00, exp_sp});
        end
    endtask

    task print_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog well past the few hundred cycles the sequence needs.
    initial begin
        #40000;
        num_errors = num_errors + 1;
        print_verdict;
    end

    // Corner cases first, then a random mix of every operation.
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check(pc, 24'h000000);
        check({8'h00, sp}, 24'h000800);
        exp_pc = 24'h000000;
        exp_sp = 16'h0800;
        run(`PCSEQ_OP_BRANCH, 1'b0, 16'h8000);
        run(`PCSEQ_OP_BRANCH, 1'b0, 16'h7fff);
        for (i = 0; i < 14; i = i + 1)
            run(i[3:0], 1'b0, r[15:0]);
        run(`PCSEQ_OP_SEQ, 1'b1, 16'h0000);
        run(`PCSEQ_OP_RETURN_EXC, 1'b0, 16'h0000);
        @(posedge ref_clk);
        rep <= 1'b1;
        run(`PCSEQ_OP_SEQ, 1'b0, 16'h0000);
        @(posedge ref_clk);
        {rep, lp, le, ls} <= {2'h1, exp_pc, 24'h001234};
        run(`PCSEQ_OP_SEQ, 1'b0, 16'h0000);
        run(`PCSEQ_OP_SEQ, 1'b0, 16'h0000);
        @(posedge ref_clk);
        lp <= 1'b0;
        for (i = 0; i < 100; i = i + 1) begin
            r = $random(seed);
            op = r[3:0] % 4'he;
            if (op > 4'ha && rets.size() == 0)
                op = `PCSEQ_OP_CALL_REL;
            run(op, r[10:8] == 3'h0, r[31:16]);
        end
        print_verdict;
    end
endmodule // tb
`default_nettype wire
